// ==== hdl/sas_pkg.sv ====
/*
  Constants, register layouts and lookup functions for the SAR converter
  sequencer. Assumes a 32-bit AXI4-Lite bus with 5 decoded address bits.
*/
`default_nettype none
package sas_pkg;
  // Byte offsets of the register words.
  localparam logic [4:0] OFF_CTRL0 = 5'h00;
  localparam logic [4:0] OFF_CTRL1 = 5'h04;
  localparam logic [4:0] OFF_PCFGL = 5'h08;
  localparam logic [4:0] OFF_PCFGH = 5'h0C;
  localparam logic [4:0] OFF_RESH  = 5'h10;
  localparam logic [4:0] OFF_RESL  = 5'h14;
  localparam logic [4:0] OFF_IRQ   = 5'h18;
  // Implemented bits of the pin configuration registers.
  localparam logic [7:0] PCFGL_MASK = 8'h9F;
  localparam logic [7:0] PCFGH_MASK = 8'hFC;
  // Conversion and post-conversion lengths in conversion clock periods.
  localparam logic [4:0] CONV_TADS = 5'h0B;
  localparam logic [4:0] WAIT_TADS = 5'h02;
  // Trial bit that opens every approximation.
  localparam logic [9:0] SAR_TOP = 10'h200;
  // Clock select code that picks the internal RC clock (low two bits).
  localparam logic [1:0] CLK_RC = 2'h3;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register 0 layout.
  typedef struct packed {
    logic       vref_neg_ext;   // 1: external negative reference pin.
    logic       vref_pos_ext;   // 1: external positive reference pin.
    logic [3:0] channel_select; // Selected analog channel.
    logic       go;             // Conversion status bit.
    logic       converter_enable; // Module on.
  } sas_ctrl0_s;

  // Control register 1 layout.
  typedef struct packed {
    logic       result_format_sel;    // 1: right justified.
    logic       calibrate;            // Stored only.
    logic [2:0] acquisition_time_sel; // Programmed acquisition.
    logic [2:0] conversion_clock_sel; // Conversion clock source.
  } sas_ctrl1_s;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b10,
    ST_WAIT = 2'b11
  } sas_state_e;

  // Acquisition length in conversion clock periods for each code.
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    unique case (code)
      3'h7: acq_tads = 5'h14;
      3'h6: acq_tads = 5'h10;
      3'h5: acq_tads = 5'h0C;
      3'h4: acq_tads = 5'h08;
      3'h3: acq_tads = 5'h06;
      3'h2: acq_tads = 5'h04;
      3'h1: acq_tads = 5'h02;
      3'h0: acq_tads = 5'h00;
    endcase
  endfunction

  // Last count of the system clock divider for each code (divide - 1).
  function automatic logic [6:0] div_last(input logic [2:0] code);
    unique case (code)
      3'h0: div_last = 7'h01;
      3'h1: div_last = 7'h07;
      3'h2: div_last = 7'h1F;
      3'h4: div_last = 7'h03;
      3'h5: div_last = 7'h0F;
      3'h6: div_last = 7'h3F;
      3'h3, 3'h7: div_last = 7'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// ==== hdl/sas_top.sv ====
/*
  SAR converter sequencer: AXI4-Lite register file, conversion clock
  generator, acquisition and successive approximation sequencer, and
  pin configuration. Assumes an external DAC and comparator: cmp_above
  is high when the held sample is at or above the offered sar_code.
  rc_tick is a one-cycle pulse per RC oscillator period, synchronous.
*/
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
// Functional notes
// - Low pin register: 1 digital, 0 analog.
// - High pin register selects channels 15 to 10.
// - Software picks supply rails or reference pins.
// - RC clock keeps converting during sleep.
// - Successive approximation on held sample.
// - Completion loads result, clears go, flags.
// - Reset turns converter off, aborts conversion.
// - Result pair has no reset value.
// - Two periods wait before next acquisition.
// - Zero acquisition code converts at once.
// - Nonzero code samples then converts automatically.
// - After completion, sampling resumes.
// - Go stays set through acquisition and conversion.
// - Holding capacitor disconnects when conversion starts.
// - Ten-bit result, 1024 steps.
// - Acquisition codes map to 20 down to 0.
// - Clock field selects divider or RC clock.
// - Conversion lasts eleven clock periods.
// - Clearing go aborts, result unchanged.
`timescale 1ns/1ps
`default_nettype none
module sas_top (
  input  wire logic        mclk,          // System clock, 250 MHz.
  input  wire logic        reset_n,       // Synchronous reset.
  input  wire logic [4:0]  s_axi_awaddr,  // Write address.
  input  wire logic        s_axi_awvalid, // Write address valid.
  output logic             s_axi_awready, // Write address ready.
  input  wire logic [31:0] s_axi_wdata,   // Write data.
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes.
  input  wire logic        s_axi_wvalid,  // Write data valid.
  output logic             s_axi_wready,  // Write data ready.
  output logic [1:0]       s_axi_bresp,   // Write response.
  output logic             s_axi_bvalid,  // Write response valid.
  input  wire logic        s_axi_bready,  // Write response ready.
  input  wire logic [4:0]  s_axi_araddr,  // Read address.
  input  wire logic        s_axi_arvalid, // Read address valid.
  output logic             s_axi_arready, // Read address ready.
  output logic [31:0]      s_axi_rdata,   // Read data.
  output logic [1:0]       s_axi_rresp,   // Read response.
  output logic             s_axi_rvalid,  // Read data valid.
  input  wire logic        s_axi_rready,  // Read data ready.
  input  wire logic        rc_tick,       // RC oscillator period pulse.
  input  wire logic        cmp_above,     // Comparator result.
  output logic [9:0]       sar_code,      // Trial code to the DAC.
  output logic             hold_connect,  // Capacitor on the input pin.
  output logic [3:0]       channel_select, // Analog mux select.
  output logic             vref_pos_ext,  // External positive reference.
  output logic             vref_neg_ext,  // External negative reference.
  output logic [15:0]      pin_digital_select, // 1: pin is digital.
  input  wire logic [15:0] pin_in,        // Raw pin input levels.
  output logic [15:0]      pin_din,       // Gated digital inputs.
  output logic             converter_irq_flag,   // Completion flag.
  output logic             converter_irq_enable  // Interrupt enable.
);

  // Bus state.
  logic        awv_q, awv_d;   // Write address held.
  logic [4:0]  awa_q, awa_d;   // Held write address.
  logic        wv_q, wv_d;     // Write data held.
  logic [7:0]  wd_q, wd_d;     // Held write byte.
  logic        ws_q, ws_d;     // Held lane 0 strobe.
  logic        bv_q, bv_d;     // Write response pending.
  logic [1:0]  br_q, br_d;     // Write response code.
  logic        rv_q, rv_d;     // Read data pending.
  logic [31:0] rd_q, rd_d;     // Read data.
  logic [1:0]  rr_q, rr_d;     // Read response code.
  logic        wr_en;          // Register write this cycle.
  logic        wr_hit;         // Write address is mapped.
  logic [7:0]  rd_byte;        // Selected read value.
  logic        rd_hit;         // Read address is mapped.

  // Core state.
  sas_pkg::sas_ctrl0_s c0_q, c0_d;    // Control register 0.
  sas_pkg::sas_ctrl1_s c1_q, c1_d;    // Control register 1.
  sas_pkg::sas_ctrl0_s wc0;           // Written control 0 view.
  logic [7:0]  pl_q, pl_d;     // Low pin configuration.
  logic [7:0]  ph_q, ph_d;     // High pin configuration.
  logic        fl_q, fl_d;     // Completion flag.
  logic        ie_q, ie_d;     // Interrupt enable.
  sas_pkg::sas_state_e st_q, st_d;    // Sequencer state.
  logic [6:0]  div_q, div_d;   // Clock divider count.
  logic [4:0]  tc_q, tc_d;     // Periods counted in a phase.
  logic [9:0]  sar_q, sar_d;   // Approximation register.
  logic [9:0]  msk_q, msk_d;   // Bit under trial.
  logic [15:0] din_q, din_d;   // Gated pin inputs.
  logic        tick;           // One conversion clock period elapsed.
  logic        done;           // Conversion completes this cycle.
  logic [9:0]  fin;            // Final decided code.
  logic [15:0] res_q, res_d;   // Result pair, no reset.

  // Ready whenever the holding slot is free and no response waits.
  assign s_axi_awready = !awv_q && !bv_q;
  assign s_axi_wready  = !wv_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign wr_en = awv_q && wv_q && ws_q && wr_hit;

  // Address map check for writes; upper address bits beyond 5 not seen.
  always_comb begin
    unique case (awa_q)
      sas_pkg::OFF_CTRL0, sas_pkg::OFF_CTRL1, sas_pkg::OFF_PCFGL,
      sas_pkg::OFF_PCFGH, sas_pkg::OFF_RESH, sas_pkg::OFF_RESL,
      sas_pkg::OFF_IRQ: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read mux; unimplemented bits read zero.
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      sas_pkg::OFF_CTRL0: rd_byte = c0_q;
      sas_pkg::OFF_CTRL1: rd_byte = c1_q;
      sas_pkg::OFF_PCFGL: rd_byte = pl_q;
      sas_pkg::OFF_PCFGH: rd_byte = ph_q;
      sas_pkg::OFF_RESH:  rd_byte = res_q[15:8];
      sas_pkg::OFF_RESL:  rd_byte = res_q[7:0];
      sas_pkg::OFF_IRQ:   rd_byte = {6'h00, ie_q, fl_q};
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // Bus next state: address and data taken in either order.
  always_comb begin
    awv_d = awv_q;
    awa_d = awa_q;
    wv_d  = wv_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awv_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wv_d = 1'b1;
      wd_d = s_axi_wdata[7:0];
      ws_d = s_axi_wstrb[0];
    end
    // Both halves held: the write takes effect and the response rises.
    if (awv_q && wv_q) begin
      awv_d = 1'b0;
      wv_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = wr_hit ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rd_d = {24'h00_0000, rd_byte};
      rr_d = rd_hit ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
    end
  end

  // Bus registers.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      awv_q <= 1'b0;
      awa_q <= 5'h00;
      wv_q  <= 1'b0;
      wd_q  <= 8'h00;
      ws_q  <= 1'b0;
      bv_q  <= 1'b0;
      br_q  <= 2'h0;
      rv_q  <= 1'b0;
      rd_q  <= 32'h0000_0000;
      rr_q  <= 2'h0;
    end else begin
      awv_q <= awv_d;
      awa_q <= awa_d;
      wv_q  <= wv_d;
      wd_q  <= wd_d;
      ws_q  <= ws_d;
      bv_q  <= bv_d;
      br_q  <= br_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
      rr_q  <= rr_d;
    end
  end

  // RC source ticks on its own oscillator, so it runs in sleep.
  assign tick = (c1_q.conversion_clock_sel[1:0] == sas_pkg::CLK_RC) ?
                rc_tick :
                (div_q == sas_pkg::div_last(c1_q.conversion_clock_sel));
  assign wc0 = wd_q;

  // Sequencer, control registers and flag next state.
  always_comb begin
    c0_d  = c0_q;
    c1_d  = c1_q;
    pl_d  = pl_q;
    ph_d  = ph_q;
    fl_d  = fl_q;
    ie_d  = ie_q;
    st_d  = st_q;
    tc_d  = tc_q;
    sar_d = sar_q;
    msk_d = msk_q;
    done  = 1'b0;
    fin   = (cmp_above ? sar_q : (sar_q & ~msk_q)) | (msk_q >> 1);
    // Divider free runs outside idle and restarts each period.
    div_d = (st_q == sas_pkg::ST_IDLE || tick) ? 7'h00 :
            div_q + 7'h01;
    // Gate digital reads of analog pins to zero.
    din_d = pin_in & pin_digital_select;
    unique case (st_q)
      sas_pkg::ST_IDLE: begin
        tc_d = 5'h00;
        if (c0_q.go && c0_q.converter_enable) begin
          // Code zero skips acquisition.
          st_d = (c1_q.acquisition_time_sel == 3'h0) ?
                 sas_pkg::ST_CONV : sas_pkg::ST_ACQ;
        end
      end
      sas_pkg::ST_ACQ: begin
        // Keep sampling for the programmed periods.
        if (tick) begin
          tc_d = tc_q + 5'h01;
          if (tc_q == sas_pkg::acq_tads(c1_q.acquisition_time_sel)
                      - 5'h01) begin
            st_d = sas_pkg::ST_CONV;
            tc_d = 5'h00;
          end
        end
      end
      sas_pkg::ST_CONV: begin
        if (tick) begin
          tc_d = tc_q + 5'h01;
          if (tc_q == 5'h00) begin
            // First period: offer the top trial bit.
            sar_d = sas_pkg::SAR_TOP;
            msk_d = sas_pkg::SAR_TOP;
          end else begin
            // Keep or drop the trial bit, try the next.
            sar_d = fin;
            msk_d = msk_q >> 1;
          end
          if (tc_q == sas_pkg::CONV_TADS - 5'h01) begin
            // Eleven periods done.
            done = 1'b1;
            c0_d.go = 1'b0;
            st_d = sas_pkg::ST_WAIT;
            tc_d = 5'h00;
          end
        end
      end
      sas_pkg::ST_WAIT: begin
        // Hold off the next acquisition two periods.
        if (tick) begin
          tc_d = tc_q + 5'h01;
          if (tc_q == sas_pkg::WAIT_TADS - 5'h01) begin
            st_d = sas_pkg::ST_IDLE;  // Sampling resumes.
          end
        end
      end
    endcase
    // Software writes; go only sticks while the module is on.
    if (wr_en) begin
      unique case (awa_q)
        sas_pkg::OFF_CTRL0: begin
          c0_d = wc0;
          c0_d.go = wc0.go && wc0.converter_enable;
          // Clearing go mid-run aborts without a result.
          if (!wc0.go && (st_q == sas_pkg::ST_ACQ ||
                          st_q == sas_pkg::ST_CONV)) begin
            done = 1'b0;
            st_d = sas_pkg::ST_WAIT;
            tc_d = 5'h00;
          end
        end
        sas_pkg::OFF_CTRL1: c1_d = wd_q;
        sas_pkg::OFF_PCFGL: pl_d = wd_q & sas_pkg::PCFGL_MASK;
        sas_pkg::OFF_PCFGH: ph_d = wd_q & sas_pkg::PCFGH_MASK;
        sas_pkg::OFF_IRQ: begin
          fl_d = wd_q[0];
          ie_d = wd_q[1];
        end
        default: begin
        end
      endcase
    end
    // Hardware set wins over a software clear.
    if (done) begin
      fl_d = 1'b1;
    end
    // Turning the module off stops everything at once.
    if (!c0_d.converter_enable) begin
      st_d = sas_pkg::ST_IDLE;
      tc_d = 5'h00;
    end
  end

  // Core registers; reset leaves the converter off and idle.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      c0_q  <= '0;
      c1_q  <= '0;
      pl_q  <= 8'h00;
      ph_q  <= 8'h00;
      fl_q  <= 1'b0;
      ie_q  <= 1'b0;
      st_q  <= sas_pkg::ST_IDLE;
      div_q <= 7'h00;
      tc_q  <= 5'h00;
      sar_q <= 10'h000;
      msk_q <= 10'h000;
      din_q <= 16'h0000;
    end else begin
      c0_q  <= c0_d;
      c1_q  <= c1_d;
      pl_q  <= pl_d;
      ph_q  <= ph_d;
      fl_q  <= fl_d;
      ie_q  <= ie_d;
      st_q  <= st_d;
      div_q <= div_d;
      tc_q  <= tc_d;
      sar_q <= sar_d;
      msk_q <= msk_d;
      din_q <= din_d;
    end
  end

  // Result pair next value: completion or software write.
  always_comb begin
    res_d = res_q;
    if (done) begin
      // Justify by the format bit, unused bits zero.
      res_d = c1_q.result_format_sel ? {6'h00, fin} : {fin, 6'h00};
    end
    if (wr_en && awa_q == sas_pkg::OFF_RESH) begin
      res_d[15:8] = wd_q;
    end
    if (wr_en && awa_q == sas_pkg::OFF_RESL) begin
      res_d[7:0] = wd_q;
    end
  end

  // The result pair deliberately has no reset.
  always_ff @(posedge mclk) begin
    res_q <= res_d;
  end

  // Capacitor samples in idle and acquisition only.
  assign hold_connect = (st_q == sas_pkg::ST_IDLE) ||
                        (st_q == sas_pkg::ST_ACQ);
  assign sar_code       = sar_q;
  assign channel_select = c0_q.channel_select;
  assign vref_pos_ext   = c0_q.vref_pos_ext;
  assign vref_neg_ext   = c0_q.vref_neg_ext;
  // Channels 9, 8, 6 and 5 have no pin and stay analog.
  assign pin_digital_select = {ph_q[7:2], 2'b00, pl_q[7], 2'b00,
                               pl_q[4:0]};
  assign pin_din              = din_q;
  assign converter_irq_flag   = fl_q;
  assign converter_irq_enable = ie_q;

endmodule // sas_top
`default_nettype wire

// ==== tb/sas_analog_model.sv ====
/*
  Analog side: pin level, sample-and-hold, comparator and RC clock.
  Assumes the bench sets the level seen on the selected pin.
*/
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model #(parameter int RC_DIV = 5) (
  input  wire logic       mclk,         // System clock.
  input  wire logic       hold_connect, // Capacitor on pin.
  input  wire logic [9:0] sar_code,     // Trial code.
  input  wire logic [9:0] pin_level,    // Pin level.
  output logic            cmp_above,    // Held at or above trial.
  output logic            rc_tick       // RC period pulse.
);
  logic [9:0] held_q = 10'h000; // Charge on the capacitor.
  int         rc_cnt = 0;       // Free running RC phase.
  // The capacitor follows the pin only while connected, so a pin
  // change during conversion cannot leak into the result.
  always @(posedge mclk) begin
    if (hold_connect) held_q <= pin_level;
    rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
  end
  // The comparator judges the held charge against the trial code.
  assign cmp_above = (held_q >= sar_code);
  assign rc_tick = (rc_cnt == 0);
endmodule // sas_analog_model
`default_nettype wire

// ==== tb/sas_properties.sv ====
/*
  Port checker for the converter sequencer.
  Assumes it is bound to sas_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module sas_properties (
  input wire logic        mclk,               // Clock.
  input wire logic        reset_n,            // Reset.
  input wire logic        s_axi_bvalid,       // Write answer.
  input wire logic        s_axi_bready,       // Write accept.
  input wire logic [1:0]  s_axi_bresp,        // Write code.
  input wire logic        s_axi_rvalid,       // Read answer.
  input wire logic        s_axi_rready,       // Read accept.
  input wire logic [31:0] s_axi_rdata,        // Read data.
  input wire logic        hold_connect,       // Sampling.
  input wire logic        converter_irq_flag, // Done flag.
  input wire logic [15:0] pin_digital_select, // Pin modes.
  input wire logic [15:0] pin_in,             // Raw pins.
  input wire logic [15:0] pin_din             // Gated pins.
);
  // Every check runs on the system clock and rests during reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Answers stand until the master takes them.
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_reset_idle: assert property ($rose(reset_n)
    |-> hold_connect && !converter_irq_flag && pin_digital_select == 0)
    else $error("not idle after reset");
  a_unimpl_pins: assert property (pin_digital_select[9:8] == 2'h0
    && pin_digital_select[6:5] == 2'h0) else $error("unused pin bit set");
  a_din_gated: assert property ($past(reset_n)
    |-> pin_din == ($past(pin_in) & $past(pin_digital_select)))
    else $error("digital input not gated");
  a_flag_after_conv: assert property ($rose(converter_irq_flag)
    |-> !hold_connect && !$past(hold_connect)) else $error("flag early");
  a_conv_not_short: assert property ($rose(converter_irq_flag)
    |-> !$past(hold_connect, 8)) else $error("conversion too short");
  a_wait_after_end: assert property ($rose(converter_irq_flag)
    |-> !hold_connect [*4]) else $error("sampling resumed early");
  a_resume_sampling: assert property ($rose(converter_irq_flag)
    |-> ##[1:300] hold_connect) else $error("sampling not resumed");
  // Main scenarios: completion, abort return, refused access.
  c_done: cover property ($rose(converter_irq_flag));
  c_resume: cover property ($rose(hold_connect) && !converter_irq_flag);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // sas_properties
bind sas_top sas_properties sas_properties_i (.mclk, .reset_n,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .hold_connect, .converter_irq_flag,
  .pin_digital_select, .pin_in, .pin_din);
`default_nettype wire

// ==== tb/test_sar_adc_sequencer.sv ====
/*
  Self-checking bench for the converter sequencer.
  Assumes sas_top, its bound checker and the analog model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_sequencer;
  localparam int RC_DIV = 5; // RC period in system clocks.
  logic mclk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, rc_tick, cmp_above;
  logic hold_connect, vref_pos_ext, vref_neg_ext;
  logic converter_irq_flag, converter_irq_enable;
  logic [4:0]  s_axi_awaddr, s_axi_araddr; // Addresses.
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat; // Data words.
  logic [3:0]  s_axi_wstrb, channel_select; // Strobes, channel.
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp; // Responses.
  logic [9:0]  sar_code, pin_level; // Trial code, pin level.
  logic [15:0] pin_digital_select, pin_in, pin_din, last; // Pins.
  int bad_count = 0;
  int checks_done = 0;
  int divs [8] = '{2, 8, 32, RC_DIV, 4, 16, 64, RC_DIV};
  int acqs [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  sas_top sas_top_i (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_tick, .cmp_above,
    .sar_code, .hold_connect, .channel_select, .vref_pos_ext,
    .vref_neg_ext, .pin_digital_select, .pin_in, .pin_din,
    .converter_irq_flag, .converter_irq_enable);
  sas_analog_model #(.RC_DIV(RC_DIV)) sas_analog_model_i (.mclk,
    .hold_connect, .sar_code, .pin_level, .cmp_above, .rc_tick);
  // Compares one value and counts the outcome.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Compares a measured cycle count against a window.
  task automatic chk_rng(input string n, input int lo, input int hi,
                         input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  // Write cycle: ready is judged at the negedge before the taking edge.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge mclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge mclk);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
    end while (!bh);
    s_axi_bready <= 1'h0;
  endtask
  // Read cycle in the same manner.
  task automatic rd(input logic [4:0] a);
    logic ah, rh;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge mclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge mclk);
      if (ah) s_axi_arvalid <= 1'h0;
    end while (!rh);
    s_axi_rready <= 1'h0;
  endtask
  // Reads a register and compares it.
  task automatic rchk(input string n, input logic [4:0] a,
                      input logic [31:0] e);
    rd(a);
    chk(n, e, rdat);
  endtask
  // Control and pin registers come up cleared, sampling on.
  task automatic t_regs();
    logic [4:0] offs [5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h18};
    for (int i = 0; i < 5; i++) rchk("reset_reg", offs[i], 0);
    @(negedge mclk);
    chk("hold", 1, hold_connect);
  endtask
  // Unused pin bits read zero; analog pins read zero.
  task automatic t_pins();
    wr(5'h08, 32'h0000_00FF);
    wr(5'h0C, 32'h0000_00FF);
    pin_in <= 16'hFFFF;
    rchk("pin_digital_select_low", 5'h08, 32'h0000_009F);
    rchk("pin_digital_select_high", 5'h0C, 32'h0000_00FC);
    @(negedge mclk);
    chk("pin_mode", 32'h0000_FC9F, pin_digital_select);
    chk("pin_din", 32'h0000_FC9F, pin_din);
    wr(5'h08, 32'h0000_0000);
    repeat (2) @(negedge mclk);
    chk("pin_din", 32'h0000_FC00, pin_din);
  endtask
  // Both external references and channel 10, then back to the rails.
  task automatic t_refs();
    wr(5'h00, 32'h0000_00E9);
    @(negedge mclk);
    chk("vref", 3, {vref_pos_ext, vref_neg_ext});
    chk("channel", 32'h0000_000A, channel_select);
    wr(5'h00, 32'h0000_0001);
    @(negedge mclk);
    chk("vref", 0, {vref_pos_ext, vref_neg_ext});
  endtask
  // One conversion: phase lengths, completion effects, result format.
  task automatic t_conv(input logic [2:0] a, input logic [2:0] c,
                        input logic f, input logic [9:0] v);
    int h, n, d, q;
    logic [15:0] e;
    d = divs[c];
    q = acqs[a];
    e = f ? {6'h00, v} : {v, 6'h00};
    pin_level <= v;
    wr(5'h04, {24'h0, f, 1'h0, a, c});
    repeat (8) @(posedge mclk);
    wr(5'h00, 32'h0000_0003);
    h = 0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (hold_connect === 1'h1) h++;
    end while (converter_irq_flag !== 1'h1 && n < 9000);
    chk_rng("acq_len", q * d - d - 2, q * d + d + 4, h);
    chk_rng("conv_len", (q + 10) * d - 2, (q + 12) * d + 4, n);
    rchk("go_done", 5'h00, 32'h0000_0001);
    rchk("flag", 5'h18, 32'h0000_0003);
    rchk("res_high", 5'h10, e[15:8]);
    rchk("res_low", 5'h14, e[7:0]);
    wr(5'h18, 32'h0000_0002);
    rchk("flag", 5'h18, 32'h0000_0002);
    repeat (2 * d + 8) @(negedge mclk);
    chk("hold", 1, hold_connect);
    last = e;
  endtask
  // Go stays set while busy; clearing it aborts and keeps the result.
  task automatic t_abort(input logic [7:0] c1);
    pin_level <= 10'h0F0;
    wr(5'h04, c1);
    wr(5'h00, 32'h0000_0003);
    repeat (100) @(posedge mclk);
    rchk("go_busy", 5'h00, 32'h0000_0003);
    wr(5'h00, 32'h0000_0001);
    repeat (2000) @(negedge mclk);
    chk("hold", 1, hold_connect);
    rchk("flag", 5'h18, 32'h0000_0002);
    rchk("res_high", 5'h10, last[15:8]);
    rchk("res_low", 5'h14, last[7:0]);
  endtask
  // Reset in mid acquisition clears control, leaves the high result byte.
  task automatic t_reset_mid();
    wr(5'h00, 32'h0000_0003);
    repeat (50) @(posedge mclk);
    reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    t_regs();
    rchk("res_high", 5'h10, last[15:8]);
  endtask
  // Unmapped address is refused both ways and reads zero.
  task automatic t_bad();
    rd(5'h1C);
    chk("rresp", sas_pkg::RESP_SLVERR, resp);
    chk("rdata", 0, rdat);
    wr(5'h1C, 32'h0000_00FF);
    chk("bresp", sas_pkg::RESP_SLVERR, resp);
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // System clock at 250 MHz.
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Cuts a hang short well past the expected run.
  initial begin
    #200000;
    bad_count++;
    results();
  end
  // Main sequence.
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    pin_in = 16'h0000;
    pin_level = 10'h000;
    repeat (6) @(posedge mclk);
    reset_n <= 1'h1;
    t_regs();
    t_pins();
    t_refs();
    wr(5'h18, 32'h0000_0002);
    @(negedge mclk);
    chk("irq_enable", 1, converter_irq_enable);
    for (int i = 0; i < 8; i++)
      t_conv(3'(i), 3'h0, 1'h1, 10'(i * 131));
    for (int i = 0; i < 8; i++)
      t_conv(3'h1, 3'(i), 1'h0, 10'h3FF - 10'(i * 97));
    t_abort(8'h86);
    t_abort(8'hBE);
    t_reset_mid();
    t_bad();
    results();
  end
endmodule // test_sar_adc_sequencer
`default_nettype wire
